// *** hw/pcma_pkg.sv ***
package pcma_pkg;
  // Clock and air timing
  localparam int CLK_NS = 25;
  localparam int SIFS_NS = 10000;
  localparam int MIFS_NS = 1875;
  localparam int SLOT_NS = 9000;
  localparam int GUARD_NS = 12000;
  localparam int US_NS = 1000;
  localparam logic [23:0] SIFS_CYC = 24'((SIFS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [23:0] MIFS_CYC = 24'((MIFS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [23:0] SLOT_CYC = 24'((SLOT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [23:0] GUARD_CYC = 24'((GUARD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [23:0] US_CYC = 24'(US_NS / CLK_NS);

  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_AIFSN = 8'h04;
  localparam logic [7:0] REG_CWMIN = 8'h08;
  localparam logic [7:0] REG_CWMAX = 8'h0c;
  localparam logic [7:0] REG_TXLIM01 = 8'h10;
  localparam logic [7:0] REG_TXLIM23 = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_NAV = 8'h1c;
  localparam logic [7:0] REG_BACKOFF = 8'h20;

  // Values after reset
  localparam logic [15:0] AIFSN_RST = 16'h2237;
  localparam logic [31:0] CWMIN_RST = 32'h03070f0f;
  localparam logic [31:0] CWMAX_RST = 32'h070f3fff;
  localparam logic [31:0] TXLIM01_RST = 32'h0200_0200;
  localparam logic [31:0] TXLIM23_RST = 32'h0200_0200;
  localparam logic [15:0] LFSR_RST = 16'hace1;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_TXOP = 1'b1
  } pcma_state_t;
endpackage

// *** hw/pcma_medium_access.sv ***
// Function
// - Beacon periods and alien BP blocks block PCA
// - Unreleased hard/private blocks with status block PCA
// - Foreign soft blocks targeting neighbour block PCA
// - Neighbour soft/PCA block start limits TXOP
// - Foreign header loads larger Duration into NAV
// - Bad-HCS header outside blocks acts as zero
// - NAV counts down at cycle resolution
// - Medium busy from CCA, NAV, activity, unavailability
// - AIFS idle required before TXOP or countdown
// - CW kept within min/max; backoff uniform draw
// - Transaction fits TXOP limit and unavailability margin
// - Immediate TXOP on fresh frames, zero backoff
// - Immediate TXOP starts transmission at once
// - Slot-based TXOP at end of PCA slot
// - Higher ready zero-backoff category takes precedence
// - TXOP bounded by limit and unavailability margin
// - Owner runs same-category transactions, peer available
// - Sole retry frame may exceed TXOP limit
// - No CTS with NAV set; response must fit
// - First frame at start; next MIFS/SIFS later
// - Responses exactly SIFS after received frame
// - Bad-FCS B-ACK continues; missed timing ends TXOP
// - Respect peer unavailability; listen when advertised
module pcma_medium_access
  import pcma_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Medium and reservation state
  input wire logic cca_busy_pin,
  input wire logic in_own_bp,
  input wire logic in_nbr_bp,
  input wire logic in_alien_bp_blk,
  input wire logic hard_priv_blk_one,
  input wire logic blk_released,
  input wire logic soft_blk_one,
  input wire logic soft_tgt_nbr,
  input wire logic soft_owner_nbr,
  input wire logic soft_owner_self,
  input wire logic in_unrel_blk,
  input wire logic [23:0] dist_unavail,
  input wire logic [23:0] dist_nbr_soft,
  // Own radio activity
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic tx_start,
  input wire logic [15:0] tx_dur_us,
  // Received header
  input wire logic hdr_end,
  input wire logic hdr_hcs_ok,
  input wire logic hdr_to_me,
  input wire logic [15:0] hdr_dur_us,
  // Per-category queue and backoff control
  input wire logic [3:0] ac_frames,
  input wire logic [3:0] ac_new,
  input wire logic [3:0] bo_invoke,
  input wire logic [3:0] bo_grow,
  // Owner transaction control
  input wire logic txn_req,
  input wire logic [23:0] txn_len,
  input wire logic txn_retry,
  input wire logic peer_unavail,
  input wire logic txop_done,
  input wire logic tx_end,
  input wire logic tx_noresp,
  input wire logic gap_mifs,
  input wire logic rx_resp_end,
  // Recipient control
  input wire logic rx_req_end,
  input wire logic rx_req_rts,
  input wire logic [23:0] resp_len,
  input wire logic avail_adv,
  input wire logic tim_required,
  // Status and strobes
  output logic medium_busy,
  output logic pca_unavail,
  output logic txop_active,
  output logic [1:0] txop_ac,
  output logic txop_start,
  output logic txop_end,
  output logic txn_ok,
  output logic txn_deny,
  output logic tx_go,
  output logic resp_go,
  output logic resp_drop,
  output logic listen
);

  typedef struct packed {
    logic [2:0] cca_s;
    logic cca_q;
    logic [23:0] nav;
    logic [23:0] own_dur;
    logic [23:0] idle_cnt;
    logic [23:0] slot_cnt;
    logic [23:0] txop_cnt;
    logic [23:0] gap_cnt;
    logic [23:0] resp_cnt;
    logic gap_run;
    logic resp_run;
    logic [15:0] lfsr;
    logic [3:0][9:0] bo;
    logic [3:0][9:0] cw;
    logic [3:0] zero_set;
    logic en;
    logic [3:0][3:0] aifsn;
    logic [3:0][7:0] cwmin;
    logic [3:0][7:0] cwmax;
    logic [3:0][15:0] txlim;
    pcma_state_t st;
    logic [1:0] ac;
    logic sole;
    logic [31:0] prdata;
    logic pslverr;
    logic txop_start;
    logic txop_end;
    logic txn_ok;
    logic txn_deny;
    logic tx_go;
    logic resp_go;
    logic resp_drop;
  } pcma_regs_t;

  pcma_regs_t r_q, r_d;

  logic unavail, busy, tick, grant_v;
  logic [1:0] grant_ac;
  logic [3:0] aifs_ok, zero_rdy, want;
  logic [23:0] dur_cyc, av_room;

  function automatic logic [23:0] aifs_cyc(input logic [3:0] n);
    return SIFS_CYC + 24'(n) * SLOT_CYC;
  endfunction

  // Availability and busy, recomputed every cycle
  always_comb begin
    unavail = in_own_bp | in_nbr_bp | in_alien_bp_blk;
    unavail = unavail | (hard_priv_blk_one & ~blk_released);
    unavail = unavail | (soft_blk_one & soft_tgt_nbr & ~soft_owner_nbr
                         & ~soft_owner_self);
    busy = r_q.cca_q | (r_q.nav != 24'h0) | tx_active | rx_active
           | (r_q.own_dur != 24'h0) | unavail;
    av_room = (dist_nbr_soft < dist_unavail) ? dist_nbr_soft
                                              : dist_unavail;
    dur_cyc = 24'(hdr_dur_us) * US_CYC;
    tick = ~busy && (r_q.idle_cnt >= SIFS_CYC)
           && (r_q.slot_cnt == SLOT_CYC - 24'h1);
  end

  // Grant decision per category
  always_comb begin
    logic [3:0] slot_win;
    slot_win = 4'h0;
    grant_v = 1'b0;
    grant_ac = 2'h0;
    for (int a = 0; a < 4; a++) begin
      aifs_ok[a] = ~busy && (r_q.idle_cnt >= aifs_cyc(r_q.aifsn[a]));
      zero_rdy[a] = (r_q.bo[a] == 10'h0) & ac_frames[a];
      slot_win[a] = tick & ac_frames[a]
                    & (((r_q.bo[a] == 10'h0) & r_q.zero_set[a] & aifs_ok[a])
                       | ((r_q.bo[a] == 10'h1) & aifs_ok[a]));
      want[a] = (ac_new[a] & (r_q.bo[a] == 10'h0) & aifs_ok[a])
                | slot_win[a];
    end
    for (int a = 0; a < 4; a++) begin
      if (want[a] && (zero_rdy >> (a + 1)) == 4'h0) begin
        grant_v = r_q.en && r_q.st == ST_IDLE;
        grant_ac = 2'(a);
      end
    end
  end

  always_comb begin
    logic [23:0] lim;
    logic fits_lim, fits_av, resp_ok;
    logic [10:0] grown;
    grown = 11'h0;
    fits_lim = 1'b0;
    fits_av = 1'b0;
    resp_ok = 1'b0;
    r_d = r_q;
    lim = 24'(r_q.txlim[r_q.ac]) * US_CYC;
    r_d.cca_s = {r_q.cca_s[1:0], cca_busy_pin};
    if (r_q.cca_s[1] == r_q.cca_s[2]) begin
      r_d.cca_q = r_q.cca_s[2];
    end
    r_d.lfsr = {r_q.lfsr[14:0],
                r_q.lfsr[15] ^ r_q.lfsr[13] ^ r_q.lfsr[12] ^ r_q.lfsr[10]};
    r_d.txop_start = 1'b0;
    r_d.txop_end = 1'b0;
    r_d.txn_ok = 1'b0;
    r_d.txn_deny = 1'b0;
    r_d.tx_go = 1'b0;
    r_d.resp_go = 1'b0;
    r_d.resp_drop = 1'b0;

    // NAV
    if (r_q.nav != 24'h0) begin
      r_d.nav = r_q.nav - 24'h1;
    end
    if (hdr_end && hdr_hcs_ok && !hdr_to_me && dur_cyc > r_q.nav) begin
      r_d.nav = dur_cyc;
    end else if (hdr_end && !hdr_hcs_ok && !in_unrel_blk) begin
      r_d.nav = r_d.nav;
    end
    if (r_q.own_dur != 24'h0) begin
      r_d.own_dur = r_q.own_dur - 24'h1;
    end
    if (tx_start) begin
      r_d.own_dur = 24'(tx_dur_us) * US_CYC;
    end

    // Idle time and PCA slot grid
    if (busy) begin
      r_d.idle_cnt = 24'h0;
      r_d.slot_cnt = 24'h0;
    end else begin
      if (r_q.idle_cnt != 24'hffffff) begin
        r_d.idle_cnt = r_q.idle_cnt + 24'h1;
      end
      if (r_q.idle_cnt >= SIFS_CYC) begin
        r_d.slot_cnt = tick ? 24'h0 : r_q.slot_cnt + 24'h1;
      end
    end

    // Backoff per category
    for (int a = 0; a < 4; a++) begin
      if (tick && aifs_ok[a] && r_q.bo[a] != 10'h0) begin
        r_d.bo[a] = r_q.bo[a] - 10'h1;
        r_d.zero_set[a] = 1'b0;
      end
      if (bo_invoke[a]) begin
        grown = {r_q.cw[a], 1'b1};
        if (!bo_grow[a]) begin
          r_d.cw[a] = 10'(r_q.cwmin[a]);
        end else if (grown > 11'(r_q.cwmax[a])) begin
          r_d.cw[a] = 10'(r_q.cwmax[a]);
        end else begin
          r_d.cw[a] = grown[9:0];
        end
        r_d.bo[a] = 10'(r_q.lfsr % (16'(r_d.cw[a]) + 16'h1));
        r_d.zero_set[a] = (r_d.bo[a] == 10'h0);
      end
    end

    // TXOP ownership
    fits_lim = (r_q.txop_cnt + txn_len <= lim)
               || (r_q.sole && txn_retry);
    fits_av = (txn_len + SIFS_CYC + GUARD_CYC <= av_room);
    case (r_q.st)
      ST_IDLE: begin
        if (grant_v) begin
          r_d.st = ST_TXOP;
          r_d.ac = grant_ac;
          r_d.txop_cnt = 24'h0;
          r_d.sole = 1'b1;
          r_d.txop_start = 1'b1;
          r_d.tx_go = 1'b1;
        end
      end
      ST_TXOP: begin
        r_d.txop_cnt = r_q.txop_cnt + 24'h1;
        if (txn_req) begin
          if (fits_lim && fits_av && !peer_unavail) begin
            r_d.txn_ok = 1'b1;
            r_d.sole = 1'b0;
          end else begin
            r_d.txn_deny = 1'b1;
            r_d.txop_end = 1'b1;
            r_d.st = ST_IDLE;
            r_d.gap_run = 1'b0;
          end
        end else if (txop_done) begin
          r_d.txop_end = 1'b1;
          r_d.st = ST_IDLE;
          r_d.gap_run = 1'b0;
        end
      end
      default: r_d.st = ST_IDLE;
    endcase

    // Owner inter-frame gap, loaded two short for load and launch flops
    if (r_q.st == ST_TXOP && tx_end && tx_noresp) begin
      r_d.gap_run = 1'b1;
      r_d.gap_cnt = (gap_mifs ? MIFS_CYC : SIFS_CYC) - 24'h2;
    end else if (r_q.st == ST_TXOP && rx_resp_end) begin
      r_d.gap_run = 1'b1;
      r_d.gap_cnt = SIFS_CYC - 24'h2;
    end else if (r_q.gap_run) begin
      if (r_q.gap_cnt == 24'h0) begin
        r_d.gap_run = 1'b0;
        r_d.tx_go = 1'b1;
      end else begin
        r_d.gap_cnt = r_q.gap_cnt - 24'h1;
      end
    end

    // Recipient response
    resp_ok = !(rx_req_rts && r_q.nav != 24'h0)
              && (SIFS_CYC + resp_len + SIFS_CYC <= dist_unavail);
    if (rx_req_end) begin
      if (resp_ok) begin
        r_d.resp_run = 1'b1;
        r_d.resp_cnt = SIFS_CYC - 24'h2;
      end else begin
        r_d.resp_drop = 1'b1;
        r_d.resp_run = 1'b0;
      end
    end else if (r_q.resp_run) begin
      if (r_q.resp_cnt == 24'h0) begin
        r_d.resp_run = 1'b0;
        r_d.resp_go = 1'b1;
      end else begin
        r_d.resp_cnt = r_q.resp_cnt - 24'h1;
      end
    end

    // APB: read data latched in setup, write at access
    r_d.pslverr = 1'b0;
    if (psel && !penable) begin
      r_d.prdata = 32'h0;
      case (paddr)
        REG_CTRL: r_d.prdata = {31'h0, r_q.en};
        REG_AIFSN: r_d.prdata = {16'h0, r_q.aifsn};
        REG_CWMIN: r_d.prdata = r_q.cwmin;
        REG_CWMAX: r_d.prdata = r_q.cwmax;
        REG_TXLIM01: r_d.prdata = {r_q.txlim[1], r_q.txlim[0]};
        REG_TXLIM23: r_d.prdata = {r_q.txlim[3], r_q.txlim[2]};
        REG_STATUS: r_d.prdata = {26'h0, unavail, busy, r_q.nav != 24'h0,
                                  r_q.ac, r_q.st == ST_TXOP};
        REG_NAV: r_d.prdata = {8'h0, r_q.nav};
        REG_BACKOFF: r_d.prdata = {r_q.bo[3][7:0], r_q.bo[2][7:0],
                                   r_q.bo[1][7:0], r_q.bo[0][7:0]};
        default: r_d.pslverr = 1'b1;
      endcase
    end else if (psel && penable) begin
      r_d.pslverr = r_q.pslverr;
      if (pwrite) begin
        case (paddr)
          REG_CTRL: r_d.en = pwdata[0];
          REG_AIFSN: r_d.aifsn = pwdata[15:0];
          REG_CWMIN: r_d.cwmin = pwdata;
          REG_CWMAX: r_d.cwmax = pwdata;
          REG_TXLIM01: r_d.txlim[1:0] = pwdata;
          REG_TXLIM23: r_d.txlim[3:2] = pwdata;
          default: r_d.en = r_q.en;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_q <= '0;
      r_q.lfsr <= LFSR_RST;
      r_q.aifsn <= AIFSN_RST;
      r_q.cwmin <= CWMIN_RST;
      r_q.cwmax <= CWMAX_RST;
      r_q.cw <= {10'h003, 10'h007, 10'h00f, 10'h00f};
      r_q.txlim <= {TXLIM23_RST, TXLIM01_RST};
      r_q.st <= ST_IDLE;
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata = r_q.prdata;
  assign pready = 1'b1;
  assign pslverr = r_q.pslverr;
  assign medium_busy = busy;
  assign pca_unavail = unavail;
  assign txop_active = (r_q.st == ST_TXOP);
  assign txop_ac = r_q.ac;
  assign txop_start = r_q.txop_start;
  assign txop_end = r_q.txop_end;
  assign txn_ok = r_q.txn_ok;
  assign txn_deny = r_q.txn_deny;
  assign tx_go = r_q.tx_go;
  assign resp_go = r_q.resp_go;
  assign resp_drop = r_q.resp_drop;
  assign listen = avail_adv & ~tim_required & ~unavail;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_unavail_bp;
    (in_own_bp || in_nbr_bp || in_alien_bp_blk) |-> pca_unavail && medium_busy;
  endproperty
  a_unavail_bp: assert property (p_unavail_bp)
    else $error("beacon period not treated as unavailable");

  property p_hard_blk;
    hard_priv_blk_one && !blk_released |-> pca_unavail;
  endproperty
  a_hard_blk: assert property (p_hard_blk)
    else $error("unreleased hard block not unavailable");

  property p_nav_load;
    hdr_end && hdr_hcs_ok && !hdr_to_me && dur_cyc > r_q.nav
      |=> r_q.nav == $past(dur_cyc);
  endproperty
  a_nav_load: assert property (p_nav_load)
    else $error("NAV not loaded from larger Duration");

  property p_nav_dec;
    r_q.nav != 24'h0 && !hdr_end |=> r_q.nav == $past(r_q.nav) - 24'h1;
  endproperty
  a_nav_dec: assert property (p_nav_dec)
    else $error("NAV did not count down");

  property p_busy_cca;
    r_q.cca_q || r_q.nav != 24'h0 || tx_active |-> medium_busy;
  endproperty
  a_busy_cca: assert property (p_busy_cca)
    else $error("medium idle while a busy cause holds");

  property p_grant;
    grant_v |=> txop_start && txop_active && txop_ac == $past(grant_ac);
  endproperty
  a_grant: assert property (p_grant)
    else $error("granted TXOP did not start");

  property p_no_idle_grant;
    txop_start |-> $past(!busy);
  endproperty
  a_no_idle_grant: assert property (p_no_idle_grant)
    else $error("TXOP started without idle medium");

  property p_cts_nav;
    rx_req_end && rx_req_rts && r_q.nav != 24'h0 |=> resp_drop ##1 !resp_go;
  endproperty
  a_cts_nav: assert property (p_cts_nav)
    else $error("CTS scheduled with NAV set");

  property p_resp_sifs;
    resp_go |-> $past(rx_req_end, 400);
  endproperty
  a_resp_sifs: assert property (p_resp_sifs)
    else $error("response not SIFS after request end");

  property p_deny_end;
    txn_deny |-> txop_end ##1 !txop_active;
  endproperty
  a_deny_end: assert property (p_deny_end)
    else $error("denied transaction did not end TXOP");

  property p_bo_draw;
    bo_invoke[0] |=> r_q.bo[0] <= r_q.cw[0];
  endproperty
  a_bo_draw: assert property (p_bo_draw)
    else $error("backoff drawn above window");

endmodule // pcma_medium_access

// *** verif/pcma_nbr_model.sv ***
module pcma_nbr_model (
  // Clock
  input wire logic clk,
  // Header of a frame heard from a neighbour
  output logic hdr_end,
  output logic hdr_hcs_ok,
  output logic hdr_to_me,
  output logic [15:0] hdr_dur_us,
  // Neighbour frame that asks us for an answer
  output logic rx_req_end,
  output logic rx_req_rts,
  output logic [23:0] resp_len
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {hdr_end, hdr_hcs_ok, hdr_to_me, hdr_dur_us} = '0;
    {rx_req_end, rx_req_rts, resp_len} = '0;
  end

  // Fields are inverted after the strobe so stale values never match
  task automatic hdr(input logic [15:0] d, input logic me, ok);
    hdr_dur_us <= d;
    hdr_to_me <= me;
    hdr_hcs_ok <= ok;
    hdr_end <= 1'b1;
    @(posedge clk);
    hdr_end <= 1'b0;
    hdr_dur_us <= ~d;
    hdr_to_me <= ~me;
    hdr_hcs_ok <= ~ok;
  endtask

  // End of a frame that needs a CTS or an acknowledgement
  task automatic req(input logic rts, input logic [23:0] len);
    rx_req_rts <= rts;
    resp_len <= len;
    rx_req_end <= 1'b1;
    @(posedge clk);
    rx_req_end <= 1'b0;
    rx_req_rts <= ~rts;
    resp_len <= ~len;
  endtask
endmodule // pcma_nbr_model

// *** verif/pcma_medium_access_bench.sv ***
module pcma_medium_access_bench
  import pcma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic cca_busy_pin, in_unrel_blk, tx_active, rx_active, tx_start;
  logic [8:0] av;
  logic in_own_bp, in_nbr_bp, in_alien_bp_blk, hard_priv_blk_one;
  logic blk_released, soft_blk_one, soft_tgt_nbr, soft_owner_nbr;
  logic soft_owner_self, hdr_end, hdr_hcs_ok, hdr_to_me, rx_req_end;
  logic [23:0] dist_unavail, dist_nbr_soft, txn_len, resp_len;
  logic [15:0] tx_dur_us, hdr_dur_us;
  logic [3:0] ac_frames, ac_new, bo_invoke, bo_grow;
  logic txn_req, txn_retry, peer_unavail, txop_done, tx_end, tx_noresp;
  logic gap_mifs, rx_resp_end, rx_req_rts, avail_adv, tim_required;
  logic medium_busy, pca_unavail, txop_active, txop_start, txop_end;
  logic txn_ok, txn_deny, tx_go, resp_go, resp_drop, listen, e;
  logic [1:0] txop_ac;
  int fails, cmp_count, n, g, dr;

  // Own, neighbour, alien, hard, released, soft, target, owner, self
  localparam logic [9:0] AV [9] = '{10'b1000000001, 10'b0100000001,
    10'b0010000001, 10'b0001000001, 10'b0001100000, 10'b0000011001,
    10'b0000011100, 10'b0000011010, 10'b0000010000};
  localparam logic [7:0] RA [6] = '{REG_CTRL, REG_AIFSN, REG_CWMIN,
    REG_CWMAX, REG_TXLIM01, REG_TXLIM23};
  localparam logic [31:0] RV [6] = '{32'h0, {16'h0, AIFSN_RST},
    CWMIN_RST, CWMAX_RST, TXLIM01_RST, TXLIM23_RST};

  assign {in_own_bp, in_nbr_bp, in_alien_bp_blk, hard_priv_blk_one,
    blk_released, soft_blk_one, soft_tgt_nbr, soft_owner_nbr,
    soft_owner_self} = av;

  pcma_medium_access DUT (.*);
  pcma_nbr_model nbr (.*);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic complete_run;
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, x);
    cmp_count++;
    if (s !== x) begin
      fails++;
      $display("[FAIL] %0t ns got %h want %h", $time, s, x);
    end
  endtask

  task automatic tk(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Cycles from the current edge until the strobe is seen
  task automatic cnt(ref logic s, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s !== 1'b1 && n < lim);
  endtask

  // Answer must be withheld and reported once
  task automatic rw(input logic rts);
    nbr.req(rts, 24'd100);
    g = 0;
    dr = 0;
    repeat (420) begin
      @(posedge clk);
      g += int'(resp_go);
      dr += int'(resp_drop);
    end
    chk(g, 0);
    chk(dr, 1);
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    complete_run;
  end

  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata, cca_busy_pin, av,
     in_unrel_blk, tx_active, rx_active, tx_start, tx_dur_us, ac_frames,
     ac_new, bo_invoke, bo_grow, txn_req, txn_len, txn_retry,
     peer_unavail, txop_done, tx_end, tx_noresp, gap_mifs, rx_resp_end,
     avail_adv, tim_required} = '0;
    sys_rst = 1'b1;
    dist_unavail = '1;
    dist_nbr_soft = '1;
    tk(8);
    sys_rst <= 1'b0;
    tk(1);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, RA[i], '0);
      chk(q, RV[i]);
    end
    apb(1'b1, REG_AIFSN, 32'h1234);
    apb(1'b0, REG_AIFSN, '0);
    chk(q, 32'h1234);
    apb(1'b1, REG_AIFSN, RV[1]);
    apb(1'b0, 8'h40, '0);
    chk(q, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, REG_NAV, 32'hffff);
    apb(1'b0, REG_NAV, '0);
    chk(q, 32'h0);
    chk(e, 1'b0);
    avail_adv <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      av <= AV[i][9:1];
      tk(2);
      chk(pca_unavail, AV[i][0]);
      chk(medium_busy, AV[i][0]);
      chk(listen, !AV[i][0]);
    end
    tim_required <= 1'b1;
    tk(2);
    chk(listen, 1'b0);
    cca_busy_pin <= 1'b1;
    tk(6);
    chk(medium_busy, 1'b1);
    cca_busy_pin <= 1'b0;
    rx_active <= 1'b1;
    tk(6);
    chk(medium_busy, 1'b1);
    rx_active <= 1'b0;
    tx_start <= 1'b1;
    tx_dur_us <= 16'd1;
    tk(1);
    tx_start <= 1'b0;
    tk(2);
    chk(medium_busy, 1'b1);
    tk(45);
    chk(medium_busy, 1'b0);
    nbr.hdr(16'd2, 1'b0, 1'b1);
    tk(1);
    nbr.hdr(16'd1, 1'b0, 1'b1);
    tk(1);
    nbr.hdr(16'd30, 1'b0, 1'b0);
    tk(1);
    nbr.hdr(16'd30, 1'b1, 1'b1);
    apb(1'b0, REG_NAV, '0);
    chk(q > 40 && q < 80, 1'b1);
    chk(medium_busy, 1'b1);
    tk(80);
    apb(1'b0, REG_NAV, '0);
    chk(q, 32'h0);
    chk(medium_busy, 1'b0);
    nbr.req(1'b0, 24'd100);
    cnt(resp_go, 1000);
    chk(n, 400);
    nbr.hdr(16'd20, 1'b0, 1'b1);
    tk(1);
    rw(1'b1);
    tk(400);
    dist_unavail <= 24'd850;
    tk(1);
    rw(1'b0);
    dist_unavail <= '1;
    apb(1'b1, REG_CTRL, 32'h1);
    tx_active <= 1'b1;
    tk(2);
    tx_active <= 1'b0;
    ac_frames <= 4'b1010;
    ac_new <= 4'b1010;
    cnt(txop_start, 3000);
    chk(n >= 1118 && n <= 1130, 1'b1);
    chk({tx_go, txop_active}, 2'b11);
    chk(txop_ac, 2'd3);
    ac_new <= 4'b0;
    txn_len <= 24'd100;
    txn_req <= 1'b1;
    tk(1);
    txn_req <= 1'b0;
    tk(1);
    chk(txn_ok, 1'b1);
    for (int k = 0; k < 3; k++) begin
      gap_mifs <= (k == 0);
      tx_noresp <= 1'b1;
      tx_end <= (k < 2);
      rx_resp_end <= (k == 2);
      tk(1);
      tx_end <= 1'b0;
      rx_resp_end <= 1'b0;
      cnt(tx_go, 1000);
      chk(n, k == 0 ? 75 : 400);
    end
    txn_len <= 24'd20480;
    txn_retry <= 1'b1;
    txn_req <= 1'b1;
    tk(1);
    txn_req <= 1'b0;
    tk(1);
    chk({txn_ok, txn_deny}, 2'b01);
    chk(txop_end, 1'b1);
    tk(1);
    chk(txop_active, 1'b0);
    bo_grow <= 4'h0;
    for (int k = 0; k < 2; k++) begin
      bo_invoke <= 4'h1;
      tk(1);
      bo_invoke <= 4'h0;
      apb(1'b0, REG_BACKOFF, '0);
      chk(q[7:0] <= (k == 0 ? 8'h0f : 8'h1f), 1'b1);
      bo_grow <= 4'h1;
    end
    complete_run;
  end
endmodule // pcma_medium_access_bench
